// file: src/gpio_port_pkg.sv
// Package for the six-bit GPIO port: I/O addresses, field layouts, carriers.
// Assumes a CPU I/O bus with byte-wide reads and writes and single-bit ops.
package gpio_port_pkg;

  localparam int unsigned PIN_COUNT = 6;
  localparam int unsigned ADDR_W    = 6;
  localparam int unsigned DATA_W    = 8;

  // I/O space addresses and their data-space aliases
  localparam logic [ADDR_W-1:0] ADDR_PIN_SAMPLE = 6'h16;
  localparam logic [ADDR_W-1:0] ADDR_DIRECTION  = 6'h17;
  localparam logic [ADDR_W-1:0] ADDR_DATA_LATCH = 6'h18;
  localparam logic [7:0] ALIAS_PIN_SAMPLE = 8'h36;
  localparam logic [7:0] ALIAS_DIRECTION  = 8'h37;
  localparam logic [7:0] ALIAS_DATA_LATCH = 8'h38;

  localparam logic [PIN_COUNT-1:0] LATCH_RESET     = 6'h00;
  localparam logic [PIN_COUNT-1:0] DIRECTION_RESET = 6'h00;

  // Alternate-function bit positions
  localparam int unsigned BIT_CAPTURE = 0;
  localparam int unsigned BIT_COMPARE = 1;
  localparam int unsigned BIT_SS      = 2;
  localparam int unsigned BIT_MOSI    = 3;
  localparam int unsigned BIT_MISO    = 4;
  localparam int unsigned BIT_SCK     = 5;

  // Bus request: byte write, or single-bit set/clear at bit_sel
  typedef struct packed {
    logic              wr_en;
    logic              set_en;
    logic              clr_en;
    logic [ADDR_W-1:0] addr;
    logic [2:0]        bit_sel;
    logic [DATA_W-1:0] wdata;
  } io_req_s;

  typedef struct packed {
    logic [PIN_COUNT-1:0] latch;
    logic [PIN_COUNT-1:0] direction;
    logic [PIN_COUNT-1:0] sync1;
    logic [PIN_COUNT-1:0] sync2;
    logic [DATA_W-1:0]    rdata;
  } port_state_s;

endpackage : gpio_port_pkg

// file: src/six_bit_gpio_port_b.sv
// Six-bit bidirectional GPIO port with latch, direction and pin-sample access.
// Assumes the CPU I/O bus is synchronous to clock; pins come from outside.
//
// What this block does
// - Six pins, each input or output.
// - Direction bit set/clear touches one pin.
// - Latch bit set/clear touches one pin.
// - Addresses 0x18 latch, 0x17 direction, 0x16 sample.
// - Sample read-only; latch, direction read/write.
// - Each pin has its own pull-up.
// - Latch bits 7:6 read zero, reset zero.
// - Direction bits 7:6 zero, reset all inputs.
// - Bit 0 capture input, bit 1 compare output.
// - Bits 2..5 are SPI SS, MOSI, MISO, SCK.
// - Direction one drives latch (bit 1 drives compare output when timer_compare_en); zero is input.
// - Pull-up only when input and latch one.
// - Latch read gives latch; sample gives pins.
// - Reset tri-states pins without clock.
`timescale 1ns/1ps

module six_bit_gpio_port_b #(
  parameter int unsigned PINS = gpio_port_pkg::PIN_COUNT
) (
  input  wire logic                              clock,
  input  wire logic                              sys_rst,
  input  wire gpio_port_pkg::io_req_s            io_req,
  input  wire logic                              rd_en,
  output logic [gpio_port_pkg::DATA_W-1:0]       rd_data,
  input  wire logic [gpio_port_pkg::PIN_COUNT-1:0] port_pin_in,
  output logic [gpio_port_pkg::PIN_COUNT-1:0]    port_pin_out,
  output logic [gpio_port_pkg::PIN_COUNT-1:0]    port_pin_oe_n,
  output logic [gpio_port_pkg::PIN_COUNT-1:0]    pull_up_en,
  output logic                                   timer_capture_input,
  input  wire logic                              timer_compare_output,
  input  wire logic                              timer_compare_en,
  output logic                                   spi_ss_in,
  output logic                                   spi_mosi_in,
  output logic                                   spi_miso_in,
  output logic                                   spi_sck_in
);

  if (PINS != gpio_port_pkg::PIN_COUNT) begin : g_bad_pins
    $error("six_bit_gpio_port_b serves exactly six pins");
  end

  gpio_port_pkg::port_state_s state_reg;
  gpio_port_pkg::port_state_s state_next;

  // Single-bit mask for set/clear; shared by both registers
  function automatic logic [gpio_port_pkg::PIN_COUNT-1:0] bit_mask(input logic [2:0] sel);
    logic [gpio_port_pkg::PIN_COUNT-1:0] m;
    m = '0;
    for (int i = 0; i < gpio_port_pkg::PIN_COUNT; i++) begin
      if (sel == 3'(i)) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction : bit_mask

  // Apply write, set or clear to a six-bit field
  function automatic logic [gpio_port_pkg::PIN_COUNT-1:0] apply_req(
    input logic [gpio_port_pkg::PIN_COUNT-1:0] cur,
    input gpio_port_pkg::io_req_s              req
  );
    logic [gpio_port_pkg::PIN_COUNT-1:0] v;
    v = cur;
    if (req.wr_en) begin
      v = req.wdata[gpio_port_pkg::PIN_COUNT-1:0];
    end else if (req.set_en) begin
      v = cur | bit_mask(req.bit_sel);
    end else if (req.clr_en) begin
      v = cur & ~bit_mask(req.bit_sel);
    end
    return v;
  endfunction : apply_req

  always_comb begin
    state_next = state_reg;
    // Sync1 is read only by sync2
    state_next.sync1 = port_pin_in;
    state_next.sync2 = state_reg.sync1;
    if (io_req.addr == gpio_port_pkg::ADDR_DATA_LATCH) begin
      state_next.latch = apply_req(state_reg.latch, io_req);
    end
    if (io_req.addr == gpio_port_pkg::ADDR_DIRECTION) begin
      state_next.direction = apply_req(state_reg.direction, io_req);
    end
    // Writes to the sample address fall through untouched
    state_next.rdata = '0;
    if (rd_en) begin
      case (io_req.addr)
        gpio_port_pkg::ADDR_DATA_LATCH:
          state_next.rdata = {2'b00, state_reg.latch};
        gpio_port_pkg::ADDR_DIRECTION:
          state_next.rdata = {2'b00, state_reg.direction};
        gpio_port_pkg::ADDR_PIN_SAMPLE:
          state_next.rdata = {2'b00, state_reg.sync2};
        default:
          state_next.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg.latch     <= gpio_port_pkg::LATCH_RESET;
      state_reg.direction <= gpio_port_pkg::DIRECTION_RESET;
      state_reg.sync1     <= '0;
      state_reg.sync2     <= '0;
      state_reg.rdata     <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rd_data = state_reg.rdata;

  // Direction is async-reset, so pins float the moment reset rises
  genvar n;
  for (n = 0; n < gpio_port_pkg::PIN_COUNT; n++) begin : g_pin
    if (n == gpio_port_pkg::BIT_COMPARE) begin : g_cmp
      // Compare output reaches port_pin_out whenever timer_compare_en is set, even when the pin is an input
      assign port_pin_out[n] = timer_compare_en ? timer_compare_output
                                                : state_reg.latch[n];
    end else begin : g_gp
      assign port_pin_out[n] = state_reg.latch[n];
    end
    assign port_pin_oe_n[n] = ~state_reg.direction[n];
    assign pull_up_en[n]    = ~state_reg.direction[n] & state_reg.latch[n];
  end

  // Software sets direction for alternate functions; no override here
  assign timer_capture_input = state_reg.sync2[gpio_port_pkg::BIT_CAPTURE];
  assign spi_ss_in   = state_reg.sync2[gpio_port_pkg::BIT_SS];
  assign spi_mosi_in = state_reg.sync2[gpio_port_pkg::BIT_MOSI];
  assign spi_miso_in = state_reg.sync2[gpio_port_pkg::BIT_MISO];
  assign spi_sck_in  = state_reg.sync2[gpio_port_pkg::BIT_SCK];

endmodule : six_bit_gpio_port_b

// file: sim/gpio_port_properties.sv
// Port checker on the top's ports; bound from the bench top file.
`timescale 1ns/1ps
module gpio_port_properties (
  input wire logic clock, sys_rst, rd_en, timer_capture_input,
  input wire gpio_port_pkg::io_req_s io_req,
  input wire logic [7:0] rd_data,
  input wire logic [5:0] port_pin_in, port_pin_oe_n, pull_up_en
);
  default clocking @(posedge clock); endclocking default disable iff (sys_rst);
  wire gpio_port_pkg::io_req_s q = io_req;
  wire [5:0] dir = ~port_pin_oe_n;
  sequence s_dir_wr; q.wr_en && q.addr == 6'h17; endsequence
  sequence s_set; !q.wr_en && q.set_en && q.addr == 6'h17; endsequence
  chk_dir_write:
    assert property (s_dir_wr |=> dir == $past(q.wdata[5:0])) else $error("dir write");
  chk_dir_setbit:
    assert property (s_set |=> dir == ($past(dir) | 6'h1 << $past(q.bit_sel))) else $error("set");
  chk_sample_ro:
    assert property (q.wr_en && q.addr == 6'h16 |=> $stable(dir)) else $error("sample write");
  chk_pull_input:
    assert property ((pull_up_en & dir) == 6'h00) else $error("pull on output");
  chk_read_idle:
    assert property (!rd_en |=> rd_data == 8'h00) else $error("idle read data");
  chk_read_high:
    assert property (rd_en |=> rd_data[7:6] == 2'h0) else $error("high read bits");
  chk_sync_two:
    assert property (!$past(sys_rst) && !$past(sys_rst, 2)
      |-> timer_capture_input == $past(port_pin_in[0], 2)) else $error("sync delay");
  chk_reset_tri:
    assert property (disable iff (1'b0) sys_rst |-> &port_pin_oe_n) else $error("reset drive");
endmodule : gpio_port_properties

// file: sim/pin_partner.sv
// Outside pin circuitry: resolves each wire from port and outside drive.
`timescale 1ns/1ps
module pin_partner (input wire logic [5:0] oe_n, drv, pull, ext_en, ext_v, output logic [5:0] pin);
  // Loose wire shows one when pulled up, else inverse of last drive, so no stale value passes
  assign pin = ~oe_n & drv | oe_n & (ext_en & ext_v | ~ext_en & (pull | ~drv));
endmodule : pin_partner

// file: sim/six_bit_gpio_port_b_tb.sv
// Port bench: table of bus steps, then reset and pin tests; pins via the partner.
`timescale 1ns/1ps
module six_bit_gpio_port_b_tb;
  logic clock = 0, sys_rst = 0, rd_en = 0, timer_compare_output = 0, timer_compare_en = 0;
  logic timer_capture_input, spi_ss_in, spi_mosi_in, spi_miso_in, spi_sck_in;
  logic [7:0] rd_data;
  logic [5:0] port_pin_in, port_pin_out, port_pin_oe_n, pull_up_en;
  logic [5:0] ext_en = 6'h3B, ext_v = 6'h2A;
  gpio_port_pkg::io_req_s io_req = '0;
  int error_cnt = 0, num_checks = 0;
  wire [7:0] alt = {3'h0, spi_sck_in, spi_miso_in, spi_mosi_in, spi_ss_in, timer_capture_input};
  logic [27:0] rows [7] = '{
    {3'h4,6'h17,11'h0FF,8'h3F}, {3'h1,6'h17,11'h200,8'h3B},
    {3'h4,6'h18,11'h0C5,8'h05}, {3'h2,6'h18,11'h400,8'h15},
    {3'h2,6'h17,11'h700,8'h3B}, {3'h4,6'h16,11'h0FF,8'h15},
    {3'h4,6'h20,11'h0AA,8'h00}};
  six_bit_gpio_port_b u_dut (.*);
  pin_partner u_pins (.oe_n(port_pin_oe_n), .drv(port_pin_out), .pull(pull_up_en), .ext_en,
    .ext_v, .pin(port_pin_in));
  initial forever #2.5 clock = ~clock;
  task step(input logic [27:0] r);
    @(negedge clock) io_req = r[27:8];
    @(negedge clock) io_req = {3'h0, r[24:19], 11'h0};
    rd_en = 1;
    @(negedge clock) rd_en = 0;
    cmp("read", r[7:0], rd_data);
  endtask : step
  task cmp(input string n, input logic [7:0] e, input logic [7:0] s);
    num_checks++;
    if (s !== e) $display("wrong value %s expected %h seen %h", n, e, s);
    if (s !== e) error_cnt++;
  endtask : cmp
  task stop_test;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test
  initial begin
    // Raise reset after time zero so the async reset branch sees an edge
    #1 sys_rst = 1;
    #59 sys_rst = 0;
    foreach (rows[i]) step(rows[i]);
    $display("bus table done");
    @(negedge clock) sys_rst = 1;
    #1 cmp("oe in reset", 8'h3F, {2'h0, port_pin_oe_n});
    @(negedge clock) sys_rst = 0;
    repeat (3) @(negedge clock);
    step({3'h0, 6'h16, 11'h0, 8'h2E});
    cmp("alt inputs", 8'h16, alt);
    step({3'h0, 6'h17, 11'h0, 8'h00});
    step({3'h0, 6'h18, 11'h0, 8'h00});
    @(negedge clock) timer_compare_en = 1;
    timer_compare_output = 1;
    @(negedge clock) cmp("compare drive", 8'h02, {2'h0, port_pin_out});
    timer_compare_output = 0;
    @(negedge clock) cmp("compare low", 8'h00, {2'h0, port_pin_out});
    timer_compare_en = 0;
    $display("reset and pin tests done");
    stop_test();
  end
endmodule : six_bit_gpio_port_b_tb
bind six_bit_gpio_port_b gpio_port_properties u_chk (.*);
